// ### dv/test_touch_sensor_host_serial_port.sv
// Purpose: Self-checking bench of the host serial port
// Assumes: Short wait step and stall limit set below
// Notes: Expected register contents kept in integers
`timescale 1ns/1ps
module test_touch_sensor_host_serial_port;
    // Four steps must outlast the ~505 cycles from a window opening to the START
    localparam [17:0] STEP = 18'h000A0;
    // Longer than any clean session (about 19500 cycles), yet short to run
    localparam [23:0] STALL = 24'h0055F0;
    reg clk, srst, msb, lsb, event_mode, conv_done, host_rdy_low, nack;
    reg [7:0] conv_events, d;
    reg [6:0] dev;
    wire scl, m_sda_low, sda_o, sda_oe, rdy_o, rdy_oe, window_open, resume_conv, discard_results;
    integer n_fail, comparisons, sys, wait_f, n;
    // Open-drain wires with pull-ups
    wire sda = (sda_oe ? sda_o : 1'b1) & !m_sda_low;
    wire rdy = (rdy_oe ? rdy_o : 1'b1) & !host_rdy_low;
    tshsp_port #(.WAIT_STEP_CYC(STEP), .STALL_CYC(STALL)) tshsp_port_i (
        .clk(clk), .srst(srst), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
        .rdy_i(rdy), .rdy_o(rdy_o), .rdy_oe(rdy_oe), .addr_select_otp_msb(msb),
        .addr_select_otp_lsb(lsb), .event_mode(event_mode), .conv_done(conv_done),
        .conv_events(conv_events), .window_open(window_open), .resume_conv(resume_conv),
        .discard_results(discard_results));
    tshsp_host_model tshsp_host_model_i (.clk(clk), .sda(sda), .scl(scl), .sda_low(m_sda_low));
    // ************************************************
    // Tasks
    // ************************************************
    task print_verdict;
        begin
            $display("Counts: %0d compared, %0d mismatched", comparisons, n_fail);
            if (n_fail == 0 && comparisons > 0) begin
                $display("Result: passed");
            end else begin
                $display("Result: failed");
            end
            $finish;
        end
    endtask
    task chk(input [7:0] got, input [7:0] exp);
        begin
            comparisons = comparisons + 1;
            if (got !== exp) begin
                n_fail = n_fail + 1;
                $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task send(input [7:0] b, input exp);
        begin
            tshsp_host_model_i.put(b, nack);
            chk(nack, exp);
        end
    endtask
    // Conversion end pulse, then window state one cycle on
    task conv(input [7:0] ev, input em, input exp);
        begin
            conv_done <= 1'b1;
            conv_events <= ev;
            event_mode <= em;
            @(posedge clk);
            conv_done <= 1'b0;
            @(posedge clk);
            #1;
            chk(window_open, exp);
            chk(rdy, !exp);
            @(posedge clk);
        end
    endtask
    // Window left unused until it times out
    task expire;
        begin
            n = 0;
            while (discard_results !== 1'b1 && n < wait_f * STEP + 40) begin
                @(posedge clk);
                #1;
                n = n + 1;
            end
            chk(n + 2 >= wait_f * STEP && n <= wait_f * STEP + 4, 1'b1);
            chk(window_open, 1'b0);
            @(posedge clk);
        end
    endtask
    // Random read of flags byte 0
    task rd_flags;
        begin
            tshsp_host_model_i.start;
            send({dev, 1'b0}, 1'b0);
            send(8'h01, 1'b0);
            tshsp_host_model_i.start;
            send({dev, 1'b1}, 1'b0);
            tshsp_host_model_i.get(1'b1, d);
            chk(d, 8'(sys));
            tshsp_host_model_i.stop;
        end
    endtask
    // Clock and watchdog
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        repeat (300000) @(posedge clk);
        n_fail = n_fail + 1;
        print_verdict;
    end
    // ************************************************
    // Main sequence
    // ************************************************
    initial begin
        srst = 1'b1;
        event_mode = 1'b0;
        conv_done = 1'b0;
        conv_events = 8'h00;
        host_rdy_low = 1'b0;
        n_fail = 0;
        comparisons = 0;
        n = $urandom(20764);
        d = 8'($urandom);
        {msb, lsb} = d[1:0];
        dev = 7'h44 + {5'h00, msb, lsb};
        sys = 8'h80;
        wait_f = 4;
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        repeat (4) @(posedge clk);
        conv(8'h00, 1'b0, 1'b1);
        expire;
        conv(8'h00, 1'b1, 1'b0);
        conv(8'h01 << ($urandom % 8), 1'b1, 1'b1);
        expire;
        host_rdy_low <= 1'b1;
        repeat (8) @(posedge clk);
        host_rdy_low <= 1'b0;
        conv(8'h00, 1'b1, 1'b1);
        expire;
        $display("Test windows done");
        conv(8'h00, 1'b0, 1'b1);
        tshsp_host_model_i.start;
        send({dev, 1'b0}, 1'b0);
        send(8'h83, 1'b0);
        send(8'($urandom), 1'b0);
        wait_f = 4 + $urandom % 4;
        send(8'(wait_f), 1'b0);
        tshsp_host_model_i.stop;
        n = 0;
        while (resume_conv !== 1'b1 && n < 40) begin
            @(posedge clk);
            #1;
            n = n + 1;
        end
        chk(resume_conv, 1'b1);
        @(posedge clk);
        conv(8'h00, 1'b0, 1'b1);
        expire;
        $display("Test write done");
        rd_flags;
        tshsp_host_model_i.start;
        send({dev, 1'b0}, 1'b0);
        send(8'h01, 1'b0);
        send(8'($urandom) & 8'h7F, 1'b0);
        tshsp_host_model_i.stop;
        sys = 0;
        rd_flags;
        $display("Test flags done");
        conv(8'h00, 1'b0, 1'b1);
        tshsp_host_model_i.start;
        send({dev ^ 7'h01, 1'b0}, 1'b1);
        tshsp_host_model_i.start;
        send({dev, 1'b0}, 1'b0);
        send(8'h01, 1'b0);
        // About 14500 cycles have gone since the first START; wait past the limit
        repeat (STALL - 24'h0036B0) @(posedge clk);
        chk(sda_oe, 1'b0);
        chk(window_open, 1'b0);
        tshsp_host_model_i.stop;
        sys = 8'h80;
        // Current-address read from the pointer left by the stalled write
        tshsp_host_model_i.start;
        send({dev, 1'b1}, 1'b0);
        tshsp_host_model_i.get(1'b1, d);
        chk(d, 8'(sys));
        tshsp_host_model_i.stop;
        $display("Test stall done");
        print_verdict;
    end
endmodule // test_touch_sensor_host_serial_port

// ### dv/tshsp_host_model.sv
// Purpose: Bus master model of the host controller
// Assumes: Pull-up on the data line outside this model; the clock line is driven directly
// Notes: Half bit of 250 cycles keeps the rate at 400 kbit/s
`timescale 1ns/1ps
module tshsp_host_model #(
    parameter HALF = 250
) (
    input wire clk,
    input wire sda,
    output reg scl,
    output reg sda_low
);
    // Bus released at time zero
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task hw(input integer k);
        begin
            repeat (k) @(posedge clk);
        end
    endtask
    // start or repeated start, data moved mid low phase
    task start;
        begin
            hw(HALF / 2);
            sda_low <= 1'b0;
            hw(HALF / 2);
            scl <= 1'b1;
            hw(HALF);
            sda_low <= 1'b1;
            hw(HALF);
            scl <= 1'b0;
        end
    endtask
    task stop;
        begin
            hw(HALF / 2);
            sda_low <= 1'b1;
            hw(HALF / 2);
            scl <= 1'b1;
            hw(HALF);
            sda_low <= 1'b0;
        end
    endtask
    // One bit, sampled at the end of the high phase
    task bit_io(input reg b, output reg r);
        begin
            hw(HALF / 2);
            sda_low <= !b;
            hw(HALF / 2);
            scl <= 1'b1;
            hw(HALF);
            r = sda;
            scl <= 1'b0;
        end
    endtask
    // Byte out, most significant bit first, then ACK slot
    task put(input reg [7:0] d, output reg nack);
        integer i;
        reg r;
        begin
            for (i = 7; i >= 0; i = i - 1) begin
                bit_io(d[i], r);
            end
            bit_io(1'b1, nack);
        end
    endtask
    // byte in, NACK on the last one
    task get(input reg last, output reg [7:0] d);
        integer i;
        reg r;
        begin
            for (i = 7; i >= 0; i = i - 1) begin
                bit_io(1'b1, r);
                d[i] = r;
            end
            bit_io(last, r);
        end
    endtask
endmodule // tshsp_host_model

// ### dv/tshsp_port_monitor.sv
// Purpose: Port checker for the host serial port
// Assumes: Sees only the ports of tshsp_port
// Notes: Bound to every tshsp_port at the foot of this file
`timescale 1ns/1ps
module tshsp_port_monitor #(
    parameter [23:0] STALL_CYC = 24'h0007D0
) (
    input wire clk,
    input wire srst,
    input wire scl_i,
    input wire sda_i,
    input wire sda_oe,
    input wire event_mode,
    input wire conv_done,
    input wire window_open,
    input wire resume_conv,
    input wire discard_results
);
    // ************************************************
    // Bus watch
    // ************************************************
    reg sda_d;
    reg started;
    reg busy;
    reg [25:0] busy_cnt;
    // START seen in window, and time since START with no STOP
    always @(posedge clk) begin
        sda_d <= sda_i;
        if (srst || !window_open) begin
            started <= 1'b0;
        end else if (scl_i && sda_d && !sda_i) begin
            started <= 1'b1;
        end
        if (srst || (scl_i && !sda_d && sda_i)) begin
            busy <= 1'b0;
        end else if (scl_i && sda_d && !sda_i) begin
            busy <= 1'b1;
        end
        busy_cnt <= busy ? busy_cnt + 26'h1 : 26'h0;
    end
    a_stream_opens: assert property (@(posedge clk) disable iff (srst)
        conv_done && !window_open && !event_mode |=> window_open)
        else $error("window stayed shut after a conversion");
    a_open_cause: assert property (@(posedge clk) disable iff (srst)
        $rose(window_open) |-> $past(conv_done))
        else $error("window opened with no conversion end");
    a_close_resume: assert property (@(posedge clk) disable iff (srst)
        $fell(window_open) |-> resume_conv)
        else $error("window closed without resume pulse");
    a_resume_pulse: assert property (@(posedge clk) disable iff (srst)
        resume_conv |=> !resume_conv)
        else $error("resume pulse longer than one cycle");
    a_discard_pair: assert property (@(posedge clk) disable iff (srst)
        discard_results |-> resume_conv && !window_open)
        else $error("discard without resume and close");
    a_wait_no_start: assert property (@(posedge clk) disable iff (srst)
        discard_results |-> !started)
        else $error("results discarded after a START");
    a_ack_steady: assert property (@(posedge clk) disable iff (srst)
        $changed(sda_oe) && !resume_conv |-> !scl_i)
        else $error("data line changed while bus clock high");
    a_stall_bound: assert property (@(posedge clk) disable iff (srst)
        busy_cnt == {2'h0, STALL_CYC} + 26'h20 |-> !sda_oe && !window_open)
        else $error("stalled transaction not abandoned");
    a_reset_quiet: assert property (@(posedge clk)
        srst |=> !window_open && !sda_oe && !resume_conv)
        else $error("outputs active after reset");
endmodule // tshsp_port_monitor

bind tshsp_port tshsp_port_monitor #(.STALL_CYC(STALL_CYC)) tshsp_port_monitor_i (
    .clk(clk),
    .srst(srst),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .sda_oe(sda_oe),
    .event_mode(event_mode),
    .conv_done(conv_done),
    .window_open(window_open),
    .resume_conv(resume_conv),
    .discard_results(discard_results)
);

// ### hdl/tshsp_consts.vh
// Purpose: Constants for the touch sensor host serial port
// Assumes: 200 MHz core clock
// Notes: Offsets are word addresses; each word holds byte 0 and byte 1
`ifndef TSHSP_CONSTS_VH
`define TSHSP_CONSTS_VH

// ****************************************************************
// Slave address
// ****************************************************************
`define TSHSP_ADDR_BASE 7'h44
`define TSHSP_ADDR_SEL_W 2

// ****************************************************************
// Register map (word address, byte lane)
// ****************************************************************
`define TSHSP_SYSFLAGS_WORD 8'h01
`define TSHSP_EVMASK_WORD 8'h82
`define TSHSP_WAITTO_WORD 8'h83
`define TSHSP_SHOW_RESET_BIT 7
`define TSHSP_SYSFLAGS_RST 8'h80
`define TSHSP_EVMASK_RST 8'hFF
`define TSHSP_WAITTO_RST 8'h04

// ****************************************************************
// Timing
// ****************************************************************
`define TSHSP_CLK_PERIOD_NS 5
`define TSHSP_WAIT_STEP_US 640
`define TSHSP_STALL_MS 62
`define TSHSP_WAIT_STEP_CYC ((`TSHSP_WAIT_STEP_US * 1000) / `TSHSP_CLK_PERIOD_NS)
`define TSHSP_STALL_CYC ((`TSHSP_STALL_MS * 1000000) / `TSHSP_CLK_PERIOD_NS)
`define TSHSP_TIMER_W 26
`define TSHSP_RELEASE_GUARD 3

`endif

// ### hdl/tshsp_port.v
// Purpose: Host serial port of a touch controller: two-wire slave plus ready line
// Assumes: 200 MHz clk, synchronous active-high srst, open-drain pins outside
// Notes: Pointer byte selects a word; byte 0 then byte 1 follow in order
`timescale 1ns/1ps
`include "tshsp_consts.vh"
module tshsp_port #(
    parameter [17:0] WAIT_STEP_CYC = `TSHSP_WAIT_STEP_CYC,
    parameter [23:0] STALL_CYC = `TSHSP_STALL_CYC
) (
    input wire clk,
    input wire srst,
    input wire scl_i,
    input wire sda_i,
    output wire sda_o,
    output reg sda_oe,
    input wire rdy_i,
    output wire rdy_o,
    output wire rdy_oe,
    input wire addr_select_otp_msb,
    input wire addr_select_otp_lsb,
    input wire event_mode,
    input wire conv_done,
    input wire [7:0] conv_events,
    output reg window_open,
    output reg resume_conv,
    output reg discard_results
);
    // ****************************************************************
    // States
    // ****************************************************************
    localparam [4:0] ST_IDLE = 5'h01;
    localparam [4:0] ST_ADDR = 5'h02;
    localparam [4:0] ST_PTR = 5'h04;
    localparam [4:0] ST_WDATA = 5'h08;
    localparam [4:0] ST_RDATA = 5'h10;

    reg [4:0] state;
    reg [3:0] bit_cnt;
    reg ack_phase;
    reg [7:0] shift_in;
    reg [7:0] tx_byte;
    reg master_nack;
    reg [8:0] ptr;
    reg [7:0] sys_flags;
    reg [7:0] event_latch;
    reg [7:0] event_mask;
    reg [7:0] wait_field;
    reg [6:0] own_addr;
    reg strap_taken;
    reg host_req;
    reg [`TSHSP_RELEASE_GUARD-1:0] open_hist;
    reg scl_d;
    reg sda_d;
    reg [7:0] rd_byte;
    reg wr_en;
    reg wait_start;
    reg stall_start;
    wire [2:0] pins_s;
    wire scl_s;
    wire sda_s;
    wire rdy_s;
    wire scl_rise;
    wire scl_fall;
    wire start_cond;
    wire stop_cond;
    wire wait_exp;
    wire stall_exp;
    wire stall_run;
    wire open_req;
    wire [25:0] wait_load;
    wire [8:0] ptr_next;

    // ****************************************************************
    // Pin capture and bus conditions
    // ****************************************************************
    tshsp_sync #(
        .W(3),
        .INIT(3'h7)
    ) u_sync (
        .clk(clk),
        .srst(srst),
        .async_in({scl_i, sda_i, rdy_i}),
        .sync_out(pins_s)
    );

    assign scl_s = pins_s[2];
    assign sda_s = pins_s[1];
    assign rdy_s = pins_s[0];

    // Delayed copies for edge detection
    always @(posedge clk) begin
        if (srst) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_d <= scl_s;
            sda_d <= sda_s;
        end
    end

    assign scl_rise = scl_s & ~scl_d;
    assign scl_fall = ~scl_s & scl_d;
    assign start_cond = scl_s & scl_d & sda_d & ~sda_s;
    assign stop_cond = scl_s & scl_d & ~sda_d & sda_s;

    // Open-drain pins only ever pull low
    assign sda_o = 1'b0;
    assign rdy_o = 1'b0;
    assign rdy_oe = window_open;

    // ****************************************************************
    // Address strap
    // ****************************************************************
    // catch OTP select after reset release
    always @(posedge clk) begin
        if (srst) begin
            strap_taken <= 1'b0;
            own_addr <= `TSHSP_ADDR_BASE;
        end else if (!strap_taken) begin
            strap_taken <= 1'b1;
            own_addr <= `TSHSP_ADDR_BASE
                | {5'h00, addr_select_otp_msb, addr_select_otp_lsb};
        end
    end

    // ****************************************************************
    // Register read mux
    // ****************************************************************
    assign ptr_next = ptr + 9'h001;

    // Byte addressed by the pointer; unmapped reads give zero
    always @* begin
        rd_byte = 8'h00;
        case (ptr)
            {`TSHSP_SYSFLAGS_WORD, 1'b0}: rd_byte = sys_flags;
            {`TSHSP_SYSFLAGS_WORD, 1'b1}: rd_byte = event_latch;
            {`TSHSP_EVMASK_WORD, 1'b0}: rd_byte = event_mask;
            {`TSHSP_WAITTO_WORD, 1'b1}: rd_byte = wait_field;
            default: rd_byte = 8'h00;
        endcase
    end

    // ****************************************************************
    // Slave state machine
    // ****************************************************************
    always @(posedge clk) begin
        if (srst) begin
            state <= ST_IDLE;
            bit_cnt <= 4'h0;
            ack_phase <= 1'b0;
            shift_in <= 8'h00;
            tx_byte <= 8'h00;
            master_nack <= 1'b0;
            ptr <= 9'h000;
            sda_oe <= 1'b0;
            wr_en <= 1'b0;
        end else begin
            wr_en <= 1'b0;
            if (stop_cond || stall_exp) begin
                state <= ST_IDLE;
                sda_oe <= 1'b0;
                ack_phase <= 1'b0;
            end else if (start_cond) begin
                state <= ST_ADDR;
                bit_cnt <= 4'h0;
                ack_phase <= 1'b0;
                sda_oe <= 1'b0;
            end else if (state != ST_IDLE) begin
                if (scl_rise) begin
                    if (bit_cnt != 4'h8) begin
                        shift_in <= {shift_in[6:0], sda_s};
                        bit_cnt <= bit_cnt + 4'h1;
                    end else begin
                        master_nack <= sda_s;
                    end
                end else if (scl_fall) begin
                    if (bit_cnt == 4'h8 && !ack_phase) begin
                        ack_phase <= 1'b1;
                        case (state)
                            ST_ADDR: begin
                                if (shift_in[7:1] == own_addr) begin
                                    sda_oe <= 1'b1;
                                end else begin
                                    state <= ST_IDLE;
                                    ack_phase <= 1'b0;
                                end
                            end
                            ST_PTR: begin
                                sda_oe <= 1'b1;
                                ptr <= {shift_in, 1'b0};
                            end
                            ST_WDATA: begin
                                sda_oe <= 1'b1;
                                wr_en <= 1'b1;
                            end
                            ST_RDATA: sda_oe <= 1'b0;
                            default: state <= ST_IDLE;
                        endcase
                    end else if (ack_phase) begin
                        ack_phase <= 1'b0;
                        bit_cnt <= 4'h0;
                        case (state)
                            ST_ADDR: begin
                                if (shift_in[0]) begin
                                    state <= ST_RDATA;
                                    tx_byte <= rd_byte;
                                    sda_oe <= ~rd_byte[7];
                                    ptr <= ptr_next;
                                end else begin
                                    state <= ST_PTR;
                                    sda_oe <= 1'b0;
                                end
                            end
                            ST_PTR: begin
                                state <= ST_WDATA;
                                sda_oe <= 1'b0;
                            end
                            ST_WDATA: begin
                                sda_oe <= 1'b0;
                                ptr <= ptr_next;
                            end
                            ST_RDATA: begin
                                if (master_nack) begin
                                    state <= ST_IDLE;
                                    sda_oe <= 1'b0;
                                end else begin
                                    tx_byte <= rd_byte;
                                    sda_oe <= ~rd_byte[7];
                                    ptr <= ptr_next;
                                end
                            end
                            default: state <= ST_IDLE;
                        endcase
                    end else if (state == ST_RDATA) begin
                        // Shift out the next data bit
                        sda_oe <= ~tx_byte[3'h7 - bit_cnt[2:0]];
                    end
                end
            end
        end
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always @(posedge clk) begin
        if (srst) begin
            sys_flags <= `TSHSP_SYSFLAGS_RST;
            event_mask <= `TSHSP_EVMASK_RST;
            wait_field <= `TSHSP_WAITTO_RST;
            event_latch <= 8'h00;
        end else begin
            if (wr_en && ptr == {`TSHSP_EVMASK_WORD, 1'b0})
                event_mask <= shift_in;
            if (wr_en && ptr == {`TSHSP_WAITTO_WORD, 1'b1})
                wait_field <= shift_in;
            if (conv_done && !window_open)
                event_latch <= conv_events;
            // stall timeout sets flag, set wins
            if (stall_exp)
                sys_flags[`TSHSP_SHOW_RESET_BIT] <= 1'b1;
            else if (wr_en && ptr == {`TSHSP_SYSFLAGS_WORD, 1'b0}
                     && !shift_in[`TSHSP_SHOW_RESET_BIT])
                sys_flags[`TSHSP_SHOW_RESET_BIT] <= 1'b0;
        end
    end

    // ****************************************************************
    // Window control
    // ****************************************************************
    // streaming opens always; event mode needs unmasked event or host request
    // mask only matters in event mode
    assign open_req = conv_done && !window_open
        && (!event_mode || (|(conv_events & event_mask)) || host_req);

    // wait time in steps of the field
    assign wait_load = {18'h00000, wait_field} * {8'h00, WAIT_STEP_CYC};

    always @(posedge clk) begin
        if (srst) begin
            window_open <= 1'b0;
            host_req <= 1'b0;
            open_hist <= {`TSHSP_RELEASE_GUARD{1'b0}};
            resume_conv <= 1'b0;
            discard_results <= 1'b0;
            wait_start <= 1'b0;
            stall_start <= 1'b0;
        end else begin
            resume_conv <= 1'b0;
            discard_results <= 1'b0;
            wait_start <= 1'b0;
            stall_start <= start_cond && !stall_run;
            open_hist <= {open_hist[`TSHSP_RELEASE_GUARD-2:0], window_open};
            // host pulls ready low to request
            if (!window_open && open_hist == {`TSHSP_RELEASE_GUARD{1'b0}} && !rdy_s)
                host_req <= 1'b1;
            if (open_req) begin
                window_open <= 1'b1;
                host_req <= 1'b0;
                wait_start <= 1'b1;
            end else if (window_open && (stop_cond || stall_exp)) begin
                window_open <= 1'b0;
                resume_conv <= 1'b1;
            end else if (window_open && wait_exp) begin
                // no START in time: drop results
                window_open <= 1'b0;
                resume_conv <= 1'b1;
                discard_results <= 1'b1;
            end
        end
    end

    // ****************************************************************
    // Timers
    // ****************************************************************
    // wait timer stops at first START
    tshsp_timer #(
        .W(`TSHSP_TIMER_W)
    ) u_wait_timer (
        .clk(clk),
        .srst(srst),
        .start(wait_start),
        .stop(start_cond | ~window_open),
        .load(wait_load),
        .expired(wait_exp),
        .running()
    );

    tshsp_timer #(
        .W(`TSHSP_TIMER_W)
    ) u_stall_timer (
        .clk(clk),
        .srst(srst),
        .start(stall_start),
        .stop(stop_cond),
        .load({2'b00, STALL_CYC}),
        .expired(stall_exp),
        .running(stall_run)
    );
endmodule // tshsp_port

// ### hdl/tshsp_sync.v
// Purpose: Two flip-flop synchroniser for pin inputs
// Assumes: Inputs are asynchronous levels
// Notes: Only the second stage may be read by other logic
`timescale 1ns/1ps
module tshsp_sync #(
    parameter W = 1,
    parameter [W-1:0] INIT = {W{1'b1}}
) (
    input wire clk,
    input wire srst,
    input wire [W-1:0] async_in,
    output reg [W-1:0] sync_out
);
    reg [W-1:0] stage1;

    // Two-stage capture
    always @(posedge clk) begin
        if (srst) begin
            stage1 <= INIT;
            sync_out <= INIT;
        end else begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end
endmodule // tshsp_sync

// ### hdl/tshsp_timer.v
// Purpose: One-shot down counter with a one-cycle expiry pulse
// Assumes: A load of zero behaves as one cycle
// Notes: Start wins over stop in the same cycle
`timescale 1ns/1ps
module tshsp_timer #(
    parameter W = 26
) (
    input wire clk,
    input wire srst,
    input wire start,
    input wire stop,
    input wire [W-1:0] load,
    output reg expired,
    output reg running
);
    reg [W-1:0] count;

    // Count down while running, pulse at the end
    always @(posedge clk) begin
        if (srst) begin
            count <= {W{1'b0}};
            running <= 1'b0;
            expired <= 1'b0;
        end else begin
            expired <= 1'b0;
            if (start) begin
                count <= load;
                running <= 1'b1;
            end else if (stop) begin
                running <= 1'b0;
            end else if (running) begin
                if (count <= {{(W-1){1'b0}}, 1'b1}) begin
                    running <= 1'b0;
                    expired <= 1'b1;
                end else begin
                    count <= count - {{(W-1){1'b0}}, 1'b1};
                end
            end
        end
    end
endmodule // tshsp_timer
